// >>> serial_eeprom_read_engine.sv
// Contract
// - Address is one or two bytes.
// - Ack last address byte; restart enters read.
// - First random-read byte from loaded address.
// - Nack plus stop ends read; standby.
// - Sequential continues from either read kind.
// - Master ack advances pointer, sends next byte.
// - Pointer wraps to zero past last location.
// - Nack and stop end sequential read.
// - Power-on guard blocks bus activity.
// - Filter pulses under 50 ns on lines.
// - Ninth clock ack; transmitter releases data.
// - Direction bit: low write, high read.
// - Current read shifts byte MSB first.
// - No ack, no stop: stay released.
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_read_engine #(
  parameter int         AW       = rd_pkg::ADDR_W,
  parameter int         AB       = rd_pkg::ADDR_BYTES,
  parameter int         DEPTH    = rd_pkg::FIFO_DEPTH,
  parameter int         GUARD    = rd_pkg::GUARD_CYC,
  parameter logic [3:0] DEV_CODE = rd_pkg::DEV_CODE_DFLT
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      link_clk,
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe,
  input  wire logic [2:0]                chip_sel,
  output logic                           mem_rd,
  output logic [AW-1:0]                  mem_addr,
  input  wire logic [rd_pkg::BYTE_W-1:0] mem_rdata
);
  import rd_pkg::*;

  // Link domain: the signals declared here run on the bus sampling clock.
  logic              lrst_s1_r;
  logic              lrst_r;
  logic [1:0]        sy1_r;
  logic [1:0]        sy2_r;
  logic [1:0]        filt_r;
  logic [1:0]        filt_q_r;
  logic [2:0]        cs1_r;
  logic [2:0]        cs2_r;
  logic [GUARD_W-1:0] guard_r;
  logic              armed_r;
  link_st_e          st_r;
  rx_phase_e         ph_r;
  logic [3:0]        cnt_r;
  logic [7:0]        sh_r;
  logic              dir_r;
  logic              mack_r;
  logic [2:0]        devb_r;
  logic [7:0]        ahi_r;
  logic [AW-1:0]     addr_l_r;
  logic              ld_tog_r;
  logic              ep_l_r;
  logic              have_r;
  logic [7:0]        stage_r;
  logic              bt_s1_r;
  logic              bt_s2_r;
  logic              bt_seen_r;
  logic              ack_tog_r;
  logic              scl;
  logic              sda;
  logic              rise;
  logic              fall;
  logic              start;
  logic              stop;
  logic              live;
  logic              dev_hit;
  logic              consume;
  logic              load_evt;
  logic [15:0]       addr_full;

  // Core-to-link byte handshake, driven in the core domain.
  logic              out_tog_r;
  logic              out_ep_r;
  logic [7:0]        out_byte_r;

  always_ff @(posedge link_clk) begin
    lrst_s1_r <= sys_rst;
    lrst_r    <= lrst_s1_r;
    sy1_r     <= {sda_i, scl_i};
    sy2_r     <= sy1_r;
    cs1_r     <= chip_sel;
    cs2_r     <= cs1_r;
  end

  // A new level is taken only after it held for longer than the noise width.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      logic [3:0] nc_r;
      always_ff @(posedge link_clk) begin
        if (lrst_r) begin
          filt_r[gi] <= 1'b1;
          nc_r       <= CNT_ZERO;
        end else if (sy2_r[gi] == filt_r[gi]) begin
          nc_r <= CNT_ZERO;
        end else if (nc_r == 4'(NOISE_CYC)) begin
          filt_r[gi] <= sy2_r[gi];
          nc_r       <= CNT_ZERO;
        end else begin
          nc_r <= nc_r + 4'h1;
        end
      end
      a_noise_filter: assert property (@(posedge link_clk) disable iff (lrst_r)
        $changed(filt_r[gi]) |-> $past(sy2_r[gi], 1) == filt_r[gi]
                                 && $past(sy2_r[gi], 2) == filt_r[gi])
        else $error("filtered line changed on a short pulse");
    end
  endgenerate

  always_ff @(posedge link_clk) begin
    filt_q_r <= lrst_r ? LINES_IDLE : filt_r;
  end

  assign scl   = filt_r[0];
  assign sda   = filt_r[1];
  assign rise  = scl && !filt_q_r[0];
  assign fall  = !scl && filt_q_r[0];
  assign start = scl && filt_q_r[0] && filt_q_r[1] && !sda;
  assign stop  = scl && filt_q_r[0] && !filt_q_r[1] && sda;
  assign live  = armed_r && !start && !stop;

  // The engine stays deaf until the bus has idled high after reset, so
  // edges seen while the supply settles start nothing.
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      guard_r <= '0;
      armed_r <= 1'b0;
    end else if (!armed_r) begin
      if (filt_r != LINES_IDLE) begin
        guard_r <= '0;
      end else if (guard_r == GUARD_W'(GUARD)) begin
        armed_r <= 1'b1;
      end else begin
        guard_r <= guard_r + 1'b1;
      end
    end
  end

  // In one-byte mode the chip-select field carries high address bits.
  assign dev_hit   = sh_r[7:4] == DEV_CODE
                     && (AB == 1 || sh_r[3:1] == cs2_r);
  assign consume   = live && fall
                     && ((st_r == ST_ACK && ph_r == PH_DEV && dir_r)
                         || (st_r == ST_MACK && mack_r));
  assign load_evt  = live && fall && st_r == ST_RX && cnt_r == BYTE_BITS
                     && ph_r == PH_ALO;
  assign addr_full = (AB == 2) ? {ahi_r, sh_r}
                               : {5'h00, devb_r, sh_r};

  always_ff @(posedge link_clk) begin
    if (lrst_r || !armed_r) begin
      st_r      <= ST_IDLE;
      ph_r      <= PH_DEV;
      cnt_r     <= CNT_ZERO;
      sh_r      <= 8'h00;
      dir_r     <= 1'b0;
      mack_r    <= 1'b0;
      devb_r    <= 3'h0;
      ahi_r     <= 8'h00;
      addr_l_r  <= '0;
      ld_tog_r  <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (start) begin
      st_r   <= ST_RX;
      ph_r   <= PH_DEV;
      cnt_r  <= CNT_ZERO;
      sda_oe <= 1'b0;
    end else if (stop) begin
      st_r   <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st_r)
        ST_RX: begin
          if (rise) begin
            sh_r  <= {sh_r[6:0], sda};
            cnt_r <= cnt_r + 4'h1;
          end else if (fall && cnt_r == BYTE_BITS) begin
            if (ph_r != PH_DEV || dev_hit) begin
              sda_oe <= 1'b1;
              st_r   <= ST_ACK;
            end else begin
              st_r <= ST_PARK;
            end
            if (ph_r == PH_DEV) begin
              dir_r  <= sh_r[0];
              devb_r <= sh_r[3:1];
            end
            if (ph_r == PH_AHI) begin
              ahi_r <= sh_r;
            end
            if (load_evt) begin
              addr_l_r <= addr_full[AW-1:0];
              ld_tog_r <= !ld_tog_r;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            cnt_r  <= CNT_ZERO;
            sda_oe <= 1'b0;
            if (consume) begin
              sh_r   <= stage_r;
              sda_oe <= !stage_r[7];
              st_r   <= ST_TX;
            end else if (ph_r == PH_DEV) begin
              ph_r <= (AB == 2) ? PH_AHI : PH_ALO;
              st_r <= ST_RX;
            end else if (ph_r == PH_AHI) begin
              ph_r <= PH_ALO;
              st_r <= ST_RX;
            end else begin
              st_r <= ST_PARK;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (cnt_r == LAST_BIT) begin
              sda_oe <= 1'b0;
              st_r   <= ST_MACK;
            end else begin
              sh_r   <= {sh_r[6:0], 1'b0};
              sda_oe <= !sh_r[6];
              cnt_r  <= cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            mack_r <= !sda;
          end else if (fall) begin
            cnt_r <= CNT_ZERO;
            if (consume) begin
              sh_r   <= stage_r;
              sda_oe <= !stage_r[7];
              st_r   <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              st_r   <= ST_PARK;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Staging register for the next byte to send, filled from the core side.
  always_ff @(posedge link_clk) begin
    bt_s1_r <= out_tog_r;
    bt_s2_r <= bt_s1_r;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      bt_seen_r <= 1'b0;
      ack_tog_r <= 1'b0;
      have_r    <= 1'b0;
      stage_r   <= 8'h00;
      ep_l_r    <= 1'b0;
    end else if (load_evt) begin
      have_r <= 1'b0;
      ep_l_r <= !ep_l_r;
    end else if (consume) begin
      have_r <= 1'b0;
    end else if (bt_s2_r != bt_seen_r
                 && (!have_r || out_ep_r != ep_l_r)) begin
      bt_seen_r <= bt_s2_r;
      ack_tog_r <= !ack_tog_r;
      if (out_ep_r == ep_l_r) begin
        have_r  <= 1'b1;
        stage_r <= out_byte_r;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    sda_o <= 1'b0;
  end

  // Core domain: array prefetch and the byte handshake towards the link.
  logic          ld_s1_r;
  logic          ld_s2_r;
  logic          ld_s3_r;
  logic          ak_s1_r;
  logic          ak_s2_r;
  logic [AW-1:0] ptr_r;
  logic          ep_c_r;
  logic          rd_dly_r;
  logic          ld_evt;
  logic          issue;
  logic          f_in_ready;
  logic          f_out_valid;
  logic [7:0]    f_out_data;
  logic          pop;

  always_ff @(posedge core_clk) begin
    ld_s1_r <= ld_tog_r;
    ld_s2_r <= ld_s1_r;
    ld_s3_r <= ld_s2_r;
    ak_s1_r <= ack_tog_r;
    ak_s2_r <= ak_s1_r;
  end

  assign ld_evt = ld_s2_r != ld_s3_r;
  assign issue  = !ld_evt && !mem_rd && !rd_dly_r && f_in_ready;
  assign pop    = !ld_evt && out_tog_r == ak_s2_r && f_out_valid;

  // The prefetch queue runs ahead of the bus; a new address discards it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ptr_r    <= '0;
      ep_c_r   <= 1'b0;
      mem_rd   <= 1'b0;
      mem_addr <= '0;
      rd_dly_r <= 1'b0;
    end else begin
      mem_rd   <= issue;
      rd_dly_r <= mem_rd && !ld_evt;
      if (ld_evt) begin
        ptr_r  <= addr_l_r;
        ep_c_r <= !ep_c_r;
      end else if (issue) begin
        mem_addr <= ptr_r;
        ptr_r    <= ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      out_tog_r  <= 1'b0;
      out_ep_r   <= 1'b0;
      out_byte_r <= 8'h00;
    end else if (pop) begin
      out_tog_r  <= !out_tog_r;
      out_ep_r   <= ep_c_r;
      out_byte_r <= f_out_data;
    end
  end

  rd_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .flush     (ld_evt),
    .in_valid  (rd_dly_r && !ld_evt),
    .in_ready  (f_in_ready),
    .in_data   (mem_rdata),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  // Checks on both domains.
  a_addr_ack: assert property (@(posedge link_clk) disable iff (lrst_r)
    load_evt |=> sda_oe && st_r == ST_ACK)
    else $error("last address byte not acknowledged");
  a_msb_first: assert property (@(posedge link_clk) disable iff (lrst_r)
    consume |=> st_r == ST_TX && sda_oe == !$past(stage_r[7]))
    else $error("read byte did not start with its top bit");
  a_next_byte: assert property (@(posedge link_clk) disable iff (lrst_r)
    (st_r == ST_MACK && consume) |=> st_r == ST_TX && cnt_r == CNT_ZERO)
    else $error("master ack did not start the next byte");
  a_nack_release: assert property (@(posedge link_clk) disable iff (lrst_r)
    (st_r == ST_MACK && live && fall && !mack_r)
      |=> st_r == ST_PARK && !sda_oe)
    else $error("data line held after a missing ack");
  a_stop_standby: assert property (@(posedge link_clk) disable iff (lrst_r)
    (stop && armed_r) |=> st_r == ST_IDLE && !sda_oe)
    else $error("stop did not return to standby");
  a_start_fresh: assert property (@(posedge link_clk) disable iff (lrst_r)
    (start && armed_r) |=> st_r == ST_RX && ph_r == PH_DEV
                           && cnt_r == CNT_ZERO)
    else $error("start did not restart address decode");
  a_guard_deaf: assert property (@(posedge link_clk) disable iff (lrst_r)
    !armed_r |=> st_r == ST_IDLE && !sda_oe)
    else $error("bus acted on before the guard armed");
  a_ack_release: assert property (@(posedge link_clk) disable iff (lrst_r)
    (st_r == ST_ACK && live && fall && !consume) |=> !sda_oe)
    else $error("ack slot not released");
  a_ptr_load: assert property (@(posedge core_clk) disable iff (sys_rst)
    ld_evt |=> ptr_r == $past(addr_l_r) && !mem_rd)
    else $error("read pointer not loaded from address");
  a_ptr_wrap: assert property (@(posedge core_clk) disable iff (sys_rst)
    (issue && ptr_r == '1) |=> ptr_r == '0 && mem_addr == '1)
    else $error("read pointer did not wrap to zero");

  c_random: cover property (@(posedge link_clk) load_evt);
  c_sequential: cover property (@(posedge link_clk)
    st_r == ST_MACK && consume);
  c_nack: cover property (@(posedge link_clk)
    st_r == ST_PARK ##[1:1000] stop);
  c_wrap: cover property (@(posedge core_clk) issue && ptr_r == '1);
endmodule
`default_nettype wire

// >>> rd_pkg.sv
`default_nettype none
package rd_pkg;
  // Clock periods of the two domains.
  localparam int CORE_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 80;
  // Pulses narrower than this are suppressed on both bus lines.
  localparam int NOISE_NS       = 50;
  localparam int NOISE_RAW      = (NOISE_NS + LINK_PERIOD_NS - 1)
                                  / LINK_PERIOD_NS;
  localparam int NOISE_CYC      = (NOISE_RAW < 1) ? 1 : NOISE_RAW;
  // Idle time the bus must show after reset before the engine arms.
  localparam int GUARD_NS       = 10000;
  localparam int GUARD_RAW      = (GUARD_NS + LINK_PERIOD_NS - 1)
                                  / LINK_PERIOD_NS;
  localparam int GUARD_CYC      = (GUARD_RAW < 1) ? 1 : GUARD_RAW;
  localparam int GUARD_W        = 12;
  // Array geometry: 13 address bits cover the 64 kbit capacity.
  localparam int ADDR_W         = 13;
  localparam int ADDR_BYTES     = 2;
  localparam int FIFO_DEPTH     = 8;
  localparam int BYTE_W         = 8;
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEV_CODE_DFLT = 4'h5;
  localparam logic       DIR_READ      = 1'b1;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [3:0] CNT_ZERO      = 4'h0;
  localparam logic [1:0] LINES_IDLE    = 2'h3;

  typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_PARK} link_st_e;
  typedef enum {PH_DEV, PH_AHI, PH_ALO} rx_phase_e;
endpackage
`default_nettype wire

// >>> rd_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// DEPTH must be a power of two.
module rd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_LVL = (PW+1)'(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW:0]  wr_r;
  logic [PW:0]  rd_r;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_r - rd_r) != FULL_LVL;
  assign out_valid = wr_r != rd_r;
  assign out_data  = mem_r[rd_r[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r[PW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// >>> ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
// Bus controller model. It owns the clock line outright and pulls the data
// line low through sda_pull; the bench resolves the wire with a pull-up.
module ctl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  localparam int DLY = 2;
  localparam int Q   = 6;

  logic last_sda;

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    last_sda = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #DLY;
  endtask

  // Works from idle or from mid-frame, so it also serves as a restart.
  task automatic start();
    sda_pull = 1'b0;
    step(Q);
    scl = 1'b1;
    step(Q);
    sda_pull = 1'b1;
    step(Q);
    scl = 1'b0;
    step(Q);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    step(Q);
    scl = 1'b1;
    step(Q);
    sda_pull = 1'b0;
    step(2 * Q);
  endtask

  task automatic send_bit(input logic b);
    sda_pull = ~b;
    step(Q);
    scl = 1'b1;
    step(Q);
    last_sda = sda;
    step(Q);
    scl = 1'b0;
    step(Q);
  endtask

  // A glitch is a low pulse well under the filter width, put on a high bit.
  task automatic recv_bit(output logic b, input logic glitch);
    sda_pull = 1'b0;
    step(Q);
    scl = 1'b1;
    step(Q);
    b = sda;
    if (glitch && sda) begin
      sda_pull = 1'b1;
      #40;
      sda_pull = 1'b0;
    end
    step(Q);
    scl = 1'b0;
    step(Q);
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    recv_bit(ack, 1'b0);
  endtask

  task automatic read_byte(input logic mack, input logic glitch,
                           output logic [7:0] d, output logic seen);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      recv_bit(b, glitch);
      d[i] = b;
    end
    send_bit(mack);
    seen = last_sda;
  endtask
endmodule
`default_nettype wire

// >>> serial_eeprom_read_engine_test.sv
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_read_engine_test;
  import rd_pkg::*;

  logic              core_clk;
  logic              sys_rst;
  logic              link_clk;
  logic              scl;
  logic              sda;
  logic              sda_o;
  logic              sda_oe;
  logic              pull;
  logic              mem_rd;
  logic [ADDR_W-1:0] mem_addr;
  logic [BYTE_W-1:0] mem_rdata;
  logic [2:0]        sel;
  int                error_cnt;
  int                total_checks;

  assign sda = ~pull & (sda_oe ? sda_o : 1'b1);

  initial begin
    core_clk = 1'b0;
    forever #(CORE_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  // Odd offset keeps the link clock out of step with the core clock.
  initial begin
    link_clk = 1'b0;
    #17;
    forever #(LINK_PERIOD_NS / 2) link_clk = ~link_clk;
  end

  // Every location holds a mix of its own address bits, so a byte from the
  // wrong place, or the right place at the wrong time, shows up.
  function automatic logic [7:0] pat(input logic [12:0] a);
    return a[7:0] ^ {a[12:8], 3'h5};
  endfunction

  always @(posedge core_clk) begin
    if (mem_rd) begin
      mem_rdata <= pat(mem_addr);
    end
  end

  serial_eeprom_read_engine u_dut (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .link_clk  (link_clk),
    .scl_i     (scl),
    .sda_i     (sda),
    .sda_o     (sda_o),
    .sda_oe    (sda_oe),
    .chip_sel  (sel),
    .mem_rd    (mem_rd),
    .mem_addr  (mem_addr),
    .mem_rdata (mem_rdata)
  );

  ctl_model u_ctl (
    .clk      (core_clk),
    .sda      (sda),
    .scl      (scl),
    .sda_pull (pull)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic dev_sel(input logic [12:0] a);
    logic ack;
    u_ctl.start();
    u_ctl.write_byte({DEV_CODE_DFLT, sel, ~DIR_READ}, ack);
    check(8'(ack), 8'h00);
    u_ctl.write_byte({3'h0, a[12:8]}, ack);
    check(8'(ack), 8'h00);
    u_ctl.write_byte(a[7:0], ack);
    check(8'(ack), 8'h00);
    u_ctl.start();
    u_ctl.write_byte({DEV_CODE_DFLT, sel, DIR_READ}, ack);
    check(8'(ack), 8'h00);
  endtask

  // Reads n bytes from a, acking all but the last, then stops the bus.
  task automatic rd_seq(input logic [12:0] a, input int n,
                        input logic glitch);
    logic [7:0]  d;
    logic        seen;
    logic [12:0] p;
    p = a;
    for (int k = 0; k < n; k++) begin
      u_ctl.read_byte(k == n - 1, glitch, d, seen);
      check(d, pat(p));
      check(8'(seen), 8'(k == n - 1));
      p = p + 13'h1;
    end
    u_ctl.stop();
    check(8'(sda_oe), 8'h00);
  endtask

  task automatic t_guard();
    logic ack;
    u_ctl.start();
    u_ctl.write_byte({DEV_CODE_DFLT, sel, DIR_READ}, ack);
    check(8'(ack), 8'h01);
    u_ctl.stop();
    u_ctl.step(150);
  endtask

  // A word for another select code must be left unanswered.
  task automatic t_wrong_sel();
    logic ack;
    u_ctl.start();
    u_ctl.write_byte({DEV_CODE_DFLT, sel ^ 3'h1, DIR_READ}, ack);
    check(8'(ack), 8'h01);
    u_ctl.stop();
  endtask

  task automatic t_current();
    logic ack;
    u_ctl.start();
    u_ctl.write_byte({DEV_CODE_DFLT, sel, DIR_READ}, ack);
    check(8'(ack), 8'h00);
    rd_seq(13'h0002, 2, 1'b0);
  endtask

  task automatic t_nostop();
    logic [7:0] d;
    logic       seen;
    dev_sel(13'h0040);
    u_ctl.read_byte(1'b1, 1'b0, d, seen);
    check(d, pat(13'h0040));
    u_ctl.read_byte(1'b1, 1'b0, d, seen);
    check(d, 8'hff);
    u_ctl.stop();
  endtask

  task automatic t_restart();
    logic ack;
    u_ctl.start();
    u_ctl.write_byte({DEV_CODE_DFLT, sel, ~DIR_READ}, ack);
    check(8'(ack), 8'h00);
    u_ctl.write_byte(8'h00, ack);
    check(8'(ack), 8'h00);
    dev_sel(13'h0777);
    rd_seq(13'h0777, 1, 1'b0);
  endtask

  initial begin
    sel          = 3'h3;
    mem_rdata    = 8'h00;
    sys_rst      = 1'b1;
    error_cnt    = 0;
    total_checks = 0;
    repeat (5) @(posedge core_clk);
    #2;
    sys_rst = 1'b0;
    u_ctl.step(10);
    t_guard();
    dev_sel(13'h0123);
    rd_seq(13'h0123, 3, 1'b1);
    dev_sel(13'h1ffe);
    rd_seq(13'h1ffe, 4, 1'b0);
    t_current();
    t_wrong_sel();
    t_nostop();
    t_restart();
    results();
  end

  // Cuts a hung run short and reports it as a mismatch.
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
